/* logic/ssw_status_regs.sv */
// Functional notes
// - eight-bit trim code drives the converter; 0x7f is the midcode level.
// - two-bit field selects midcode level 1.25, 1.0, 0.8 or 0.6 V.
// - a code above the upper limit is replaced by the upper limit.
// - a code below the lower limit is replaced by the lower limit.
// - warning is the OR of all limit results and secondary detectors.
// - secondary detectors count only when the dual input is digital.
// - status reads show live levels, never latched.
// - overvoltage low byte: dual three..one or supplies, high-voltage, supplies four..one.
// - overvoltage high byte: bit1 dual five or high-voltage, bit0 dual four.
// - undervoltage low byte uses the overvoltage low layout.
// - undervoltage high byte: bit1 dual five or high-voltage, bit0 dual four.
// - limit low byte holds eight channel limit results.
// - limit high byte holds dual five and four results in bits 1..0.
// - input status byte shows dual five..one levels in bits 4..0.
`timescale 1ns/1ps
module ssw_status_regs (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  // register port
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  input  wire logic [7:0]       i_reg_wdata,
  output logic      [7:0]       o_reg_rdata,
  // monitored levels
  input  wire ssw_pkg::ssw_detect_t i_detect,
  input  wire logic [4:0]       i_dual_is_digital,
  // outputs
  output logic                  o_warning,
  output ssw_pkg::ssw_trim_t    o_trim
);
  import ssw_pkg::*;

  logic [7:0]  trim_code_r;
  logic [7:0]  trim_upper_r;
  logic [7:0]  trim_lower_r;
  logic [2:0]  trim_ctrl_r;
  logic [7:0]  clamp_code;
  logic        clamp_unsafe;
  logic        trim_en;
  logic [4:0]  ov_dual_view;
  logic [4:0]  uv_dual_view;
  logic [4:0]  sec_ov;
  logic [4:0]  sec_uv;
  logic [7:0]  ov_low;
  logic [7:0]  ov_high;
  logic [7:0]  uv_low;
  logic [7:0]  uv_high;
  logic [7:0]  lim_low;
  logic [7:0]  lim_high;
  logic [7:0]  gpi_byte;
  logic [7:0]  rdata_nxt;
  logic        warning_nxt;

  assign trim_en = trim_ctrl_r[SSW_CTRL_EN_BIT];

  // software writes to the trim registers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      trim_code_r  <= SSW_RST_TRIM_CODE;
      trim_upper_r <= SSW_RST_TRIM_UPPER;
      trim_lower_r <= SSW_RST_TRIM_LOWER;
      trim_ctrl_r  <= SSW_RST_TRIM_CTRL;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        SSW_OFF_TRIM_CODE:  trim_code_r  <= i_reg_wdata;
        SSW_OFF_TRIM_UPPER: trim_upper_r <= i_reg_wdata;
        SSW_OFF_TRIM_LOWER: trim_lower_r <= i_reg_wdata;
        SSW_OFF_TRIM_CTRL:  trim_ctrl_r  <= i_reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // window limiting of the written code
  // a crossed window is flagged instead of clamped: neither limit is a safe pick
  ssw_trim_clamp u_clamp (
    .i_code   (trim_code_r),
    .i_upper  (trim_upper_r),
    .i_lower  (trim_lower_r),
    .o_code   (clamp_code),
    .o_unsafe (clamp_unsafe)
  );

  // applied converter drive
  // code freezes while disabled or unsafe so the converter never sees a stray code
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_trim.drive  <= 1'b0;
      o_trim.unsafe <= 1'b0;
      o_trim.midsel <= SSW_MID_1V25;
      o_trim.code   <= SSW_RST_TRIM_CODE;
    end else begin
      o_trim.unsafe <= clamp_unsafe;
      o_trim.drive  <= trim_en & ~clamp_unsafe;
      o_trim.midsel <= ssw_midsel_t'(trim_ctrl_r[SSW_CTRL_SEL_MSB:SSW_CTRL_SEL_LSB]);
      if (trim_en && !clamp_unsafe) begin
        o_trim.code <= clamp_code;
      end
    end
  end

  // dual-function bit view and secondary detector gating
  // a digital dual input hands its status bit to the paired supply's secondary detector
  for (genvar i = 0; i < SSW_NUM_DUAL; i++) begin : g_dual
    assign ov_dual_view[i] = i_dual_is_digital[i] ? i_detect.ov_second[i] : i_detect.ov_dual[i];
    assign uv_dual_view[i] = i_dual_is_digital[i] ? i_detect.uv_second[i] : i_detect.uv_dual[i];
    assign sec_ov[i]       = i_dual_is_digital[i] & i_detect.ov_second[i];
    assign sec_uv[i]       = i_dual_is_digital[i] & i_detect.uv_second[i];
  end

  // live status bytes
  assign ov_low   = {ov_dual_view[2:0], i_detect.ov_main};
  assign ov_high  = {6'h00, ov_dual_view[4:3]};
  assign uv_low   = {uv_dual_view[2:0], i_detect.uv_main};
  assign uv_high  = {6'h00, uv_dual_view[4:3]};
  assign lim_low  = i_detect.limit[7:0];
  assign lim_high = {6'h00, i_detect.limit[9:8]};
  assign gpi_byte = {3'h0, i_detect.gpi_level};

  // read decode; unmapped offsets read zero
  always_comb begin
    unique case (i_reg_addr)
      SSW_OFF_TRIM_CODE:  rdata_nxt = trim_code_r;
      SSW_OFF_TRIM_UPPER: rdata_nxt = trim_upper_r;
      SSW_OFF_TRIM_LOWER: rdata_nxt = trim_lower_r;
      SSW_OFF_TRIM_CTRL:  rdata_nxt = {5'h00, trim_ctrl_r};
      SSW_OFF_OV_LOW:     rdata_nxt = ov_low;
      SSW_OFF_OV_HIGH:    rdata_nxt = ov_high;
      SSW_OFF_UV_LOW:     rdata_nxt = uv_low;
      SSW_OFF_UV_HIGH:    rdata_nxt = uv_high;
      SSW_OFF_LIM_LOW:    rdata_nxt = lim_low;
      SSW_OFF_LIM_HIGH:   rdata_nxt = lim_high;
      SSW_OFF_GPI:        rdata_nxt = gpi_byte;
      default:            rdata_nxt = 8'h00;
    endcase
  end

  // read data capture, sampled at the read strobe
  // status bytes feed straight in, so two reads may differ while levels move
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // wide-or warning for the sequencing engine
  // registered so the engine sees one clean level per clock
  assign warning_nxt = (|i_detect.limit) | (|sec_ov) | (|sec_uv);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_warning <= 1'b0;
    end else begin
      o_warning <= warning_nxt;
    end
  end

  // checks on the trim path and status view
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  midcode_pass_a: assert property (
    (trim_en && trim_code_r == SSW_MIDCODE && trim_lower_r <= SSW_MIDCODE && trim_upper_r >= SSW_MIDCODE)
      |=> (o_trim.code == SSW_MIDCODE && o_trim.drive))
    else $error("midcode not applied");

  midsel_follow_a: assert property (
    ##1 (o_trim.midsel == $past(trim_ctrl_r[1:0])))
    else $error("midcode select not applied");

  upper_clamp_a: assert property (
    (trim_en && trim_lower_r <= trim_upper_r && trim_code_r > trim_upper_r)
      |=> (o_trim.code == $past(trim_upper_r)))
    else $error("upper limit not applied");

  lower_clamp_a: assert property (
    (trim_en && trim_lower_r <= trim_upper_r && trim_code_r < trim_lower_r)
      |=> (o_trim.code == $past(trim_lower_r)))
    else $error("lower limit not applied");

  unsafe_off_a: assert property (
    (trim_lower_r > trim_upper_r) |=> (!o_trim.drive && o_trim.unsafe && $stable(o_trim.code)))
    else $error("unsafe limits still driven");

  disabled_hold_a: assert property (
    (!trim_en) |=> (!o_trim.drive && $stable(o_trim.code)))
    else $error("disabled converter changed");

  warning_limit_a: assert property (
    (|i_detect.limit) |=> o_warning)
    else $error("limit result missed by warning");

  secondary_gate_a: assert property (
    (i_detect.limit == 10'h000 && i_dual_is_digital == 5'h00) |=> !o_warning)
    else $error("warning from gated detector");

  live_gpi_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_GPI) |=> (o_reg_rdata == {3'h0, $past(i_detect.gpi_level)}))
    else $error("input status read wrong");

  ov_low_read_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_OV_LOW && i_dual_is_digital[0])
      |=> (o_reg_rdata[4:0] == $past(i_detect.ov_main) && o_reg_rdata[5] == $past(i_detect.ov_second[0])))
    else $error("overvoltage low byte wrong");

  ov_high_read_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_OV_HIGH && !i_dual_is_digital[4])
      |=> (o_reg_rdata[7:2] == 6'h00 && o_reg_rdata[1] == $past(i_detect.ov_dual[4])))
    else $error("overvoltage high byte wrong");

  uv_low_read_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_UV_LOW && !i_dual_is_digital[2])
      |=> (o_reg_rdata == {$past(i_detect.uv_dual[2]), $past(uv_dual_view[1:0]), $past(i_detect.uv_main)}))
    else $error("undervoltage low byte wrong");

  uv_high_read_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_UV_HIGH && i_dual_is_digital[3])
      |=> (o_reg_rdata[7:2] == 6'h00 && o_reg_rdata[0] == $past(i_detect.uv_second[3])))
    else $error("undervoltage high byte wrong");

  limit_read_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_LIM_LOW) ##1 (i_reg_rd && i_reg_addr == SSW_OFF_LIM_HIGH)
      |=> (o_reg_rdata == {6'h00, $past(i_detect.limit[9:8])}))
    else $error("limit status read wrong");

  status_live_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_GPI) ##1 (i_reg_rd && i_reg_addr == SSW_OFF_GPI && $changed(i_detect.gpi_level))
      |=> (o_reg_rdata != $past(o_reg_rdata)))
    else $error("status read appears latched");

  // dual bits, limit low byte, unused high bits and read data hold of the status reads
  ov_low_dual_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_OV_LOW)
      |=> (o_reg_rdata[7:5] == $past((i_dual_is_digital[2:0] & i_detect.ov_second[2:0]) |
                                     (~i_dual_is_digital[2:0] & i_detect.ov_dual[2:0]))))
    else $error("overvoltage dual bits wrong");

  ov_high_dual_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_OV_HIGH)
      |=> (o_reg_rdata[1:0] == $past((i_dual_is_digital[4:3] & i_detect.ov_second[4:3]) |
                                     (~i_dual_is_digital[4:3] & i_detect.ov_dual[4:3]))))
    else $error("overvoltage high pair wrong");

  uv_low_dual_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_UV_LOW)
      |=> (o_reg_rdata[7:5] == $past((i_dual_is_digital[2:0] & i_detect.uv_second[2:0]) |
                                     (~i_dual_is_digital[2:0] & i_detect.uv_dual[2:0]))))
    else $error("undervoltage dual bits wrong");

  uv_high_dual_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_UV_HIGH)
      |=> (o_reg_rdata[1:0] == $past((i_dual_is_digital[4:3] & i_detect.uv_second[4:3]) |
                                     (~i_dual_is_digital[4:3] & i_detect.uv_dual[4:3]))))
    else $error("undervoltage high pair wrong");

  lim_low_read_a: assert property (
    (i_reg_rd && i_reg_addr == SSW_OFF_LIM_LOW) |=> (o_reg_rdata == $past(i_detect.limit[7:0])))
    else $error("limit low byte wrong");

  high_unused_a: assert property (
    (i_reg_rd && (i_reg_addr == SSW_OFF_OV_HIGH || i_reg_addr == SSW_OFF_UV_HIGH || i_reg_addr == SSW_OFF_LIM_HIGH))
      |=> (o_reg_rdata[7:2] == 6'h00))
    else $error("unused status bits set");

  rdata_hold_a: assert property (
    (!i_reg_rd) |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");

  // trim window and enable
  inside_pass_a: assert property (
    (trim_en && trim_lower_r <= trim_code_r && trim_code_r <= trim_upper_r)
      |=> (o_trim.code == $past(trim_code_r)))
    else $error("code inside window altered");

  safe_flag_a: assert property (
    (trim_lower_r <= trim_upper_r) |=> !o_trim.unsafe)
    else $error("unsafe flag on a sound window");

  enable_drive_a: assert property (
    (trim_en && trim_lower_r <= trim_upper_r) |=> o_trim.drive)
    else $error("enabled converter not driven");

  // warning sources
  warning_second_a: assert property (
    (|(i_dual_is_digital & (i_detect.ov_second | i_detect.uv_second))) |=> o_warning)
    else $error("secondary detector missed by warning");

  warning_quiet_a: assert property (
    (i_detect.limit == 10'h000 && (i_dual_is_digital & (i_detect.ov_second | i_detect.uv_second)) == 5'h00)
      |=> !o_warning)
    else $error("warning without a source");

  clamp_hit_c: cover property (trim_en && trim_code_r > trim_upper_r ##1 o_trim.drive);
  unsafe_c:    cover property (trim_en && trim_lower_r > trim_upper_r ##1 o_trim.unsafe);
  warning_c:   cover property (!o_warning ##1 o_warning);
  dual_dig_c:  cover property (i_dual_is_digital != 5'h00 && (|sec_ov) ##1 o_warning);
  midcode_c:   cover property (trim_en && trim_code_r == SSW_MIDCODE ##1 o_trim.drive);

endmodule

/* logic/ssw_pkg.sv */
package ssw_pkg;

  // register offsets
  localparam logic [7:0] SSW_OFF_TRIM_CTRL  = 8'h55;
  localparam logic [7:0] SSW_OFF_TRIM_CODE  = 8'h5d;
  localparam logic [7:0] SSW_OFF_TRIM_UPPER = 8'h65;
  localparam logic [7:0] SSW_OFF_TRIM_LOWER = 8'h6d;
  localparam logic [7:0] SSW_OFF_OV_LOW     = 8'he2;
  localparam logic [7:0] SSW_OFF_OV_HIGH    = 8'he3;
  localparam logic [7:0] SSW_OFF_UV_LOW     = 8'he4;
  localparam logic [7:0] SSW_OFF_UV_HIGH    = 8'he5;
  localparam logic [7:0] SSW_OFF_LIM_LOW    = 8'he6;
  localparam logic [7:0] SSW_OFF_LIM_HIGH   = 8'he7;
  localparam logic [7:0] SSW_OFF_GPI        = 8'he8;

  // values after reset
  localparam logic [7:0] SSW_MIDCODE        = 8'h7f;
  localparam logic [7:0] SSW_RST_TRIM_CODE  = SSW_MIDCODE;
  localparam logic [7:0] SSW_RST_TRIM_UPPER = 8'hff;
  localparam logic [7:0] SSW_RST_TRIM_LOWER = 8'h00;
  localparam logic [2:0] SSW_RST_TRIM_CTRL  = 3'h0;

  // control field positions
  localparam int SSW_CTRL_EN_BIT  = 2;
  localparam int SSW_CTRL_SEL_MSB = 1;
  localparam int SSW_CTRL_SEL_LSB = 0;

  // channel counts
  localparam int SSW_NUM_MAIN = 5;
  localparam int SSW_NUM_DUAL = 5;

  // midcode level choice
  typedef enum logic [1:0] {
    SSW_MID_1V25 = 2'b00,
    SSW_MID_1V00 = 2'b01,
    SSW_MID_0V80 = 2'b10,
    SSW_MID_0V60 = 2'b11
  } ssw_midsel_t;

  // comparator and input levels; main/second index 0..3 supply one..four, 4 high-voltage
  typedef struct packed {
    logic [4:0] ov_main;
    logic [4:0] uv_main;
    logic [4:0] ov_dual;
    logic [4:0] uv_dual;
    logic [4:0] ov_second;
    logic [4:0] uv_second;
    logic [9:0] limit;
    logic [4:0] gpi_level;
  } ssw_detect_t;

  // trim converter drive
  typedef struct packed {
    logic        drive;
    logic        unsafe;
    ssw_midsel_t midsel;
    logic [7:0]  code;
  } ssw_trim_t;

endpackage

/* logic/ssw_trim_clamp.sv */
`timescale 1ns/1ps
module ssw_trim_clamp (
  // codes
  input  wire logic [7:0] i_code,
  input  wire logic [7:0] i_upper,
  input  wire logic [7:0] i_lower,
  // result
  output logic      [7:0] o_code,
  output logic            o_unsafe
);

  // limit the written code into the window
  always_comb begin
    o_unsafe = (i_lower > i_upper);
    if (i_code > i_upper) begin
      o_code = i_upper;
    end else if (i_code < i_lower) begin
      o_code = i_lower;
    end else begin
      o_code = i_code;
    end
  end

endmodule

/* verification/ssw_status_regs_test.sv */
`timescale 1ns/1ps
module ssw_status_regs_test;
  import ssw_pkg::*;
  logic        i_core_clk;
  logic        i_reset;
  logic [7:0]  i_reg_addr;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic [7:0]  i_reg_wdata;
  logic [7:0]  o_reg_rdata;
  ssw_detect_t i_detect;
  logic [4:0]  i_dual_is_digital;
  logic        o_warning;
  ssw_trim_t   o_trim;
  logic        pt;
  logic        pw;
  logic        rd_d;
  logic        pt_d;
  logic        pw_d;
  logic [7:0]  rd_q[$];
  ssw_trim_t   trim_q[$];
  logic        warn_q[$];
  int          fail_count;
  int          num_checks;
  int          cycles;

  ssw_status_regs dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_detect(i_detect), .i_dual_is_digital(i_dual_is_digital), .o_warning(o_warning), .o_trim(o_trim));

  // free-running clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic wrap_up();
    if (rd_q.size() + trim_q.size() + warn_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp_rdata(logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected read data exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_trim(ssw_trim_t e, ssw_trim_t g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected trim output exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_warn(logic e, logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected warning exp %b got %b", e, g);
    end
  endtask

  // probe flags and timeout, sampled with the design
  always @(posedge i_core_clk) begin
    rd_d <= i_reg_rd;
    pt_d <= pt;
    pw_d <= pw;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  // results settle by the falling edge; oldest note is compared
  always @(negedge i_core_clk) begin
    if (rd_d) cmp_rdata(rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx, o_reg_rdata);
    if (pt_d) cmp_trim(trim_q.size() > 0 ? trim_q.pop_front() : 'x, o_trim);
    if (pw_d) cmp_warn(warn_q.size() > 0 ? warn_q.pop_front() : 1'bx, o_warning);
  end

  // one bus cycle, launched at a falling edge
  task automatic cyc(logic w, logic r, logic [7:0] a, logic [7:0] d, logic t, logic wn);
    i_reg_wr = w;
    i_reg_rd = r;
    i_reg_addr = a;
    i_reg_wdata = d;
    pt = t;
    pw = wn;
    @(negedge i_core_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    cyc(1'b1, 1'b0, a, d, 1'b0, 1'b0);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e, logic wn = 1'b0);
    rd_q.push_back(e);
    cyc(1'b0, 1'b1, a, 8'h00, 1'b0, wn);
  endtask

  task automatic tchk(logic dr, logic un, logic [1:0] ms, logic [7:0] c);
    trim_q.push_back('{dr, un, ssw_midsel_t'(ms), c});
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
  endtask

  // dual status bit: secondary detector when digital, else dual detector
  function automatic logic [4:0] pick(logic [4:0] dual, logic [4:0] sec, logic [4:0] dig);
    return (dig & sec) | (~dig & dual);
  endfunction

  initial begin
    logic [63:0] rnd;
    logic [7:0]  c;
    logic [4:0]  ovs;
    logic [4:0]  uvs;
    ssw_detect_t det;
    i_reset = 1'b1;
    i_detect = '0;
    i_dual_is_digital = 5'h00;
    pt = 1'b0;
    pw = 1'b0;
    rd_d = 1'b0;
    pt_d = 1'b0;
    pw_d = 1'b0;
    cycles = 0;
    fail_count = 0;
    num_checks = 0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    rnd = {32'h0, $urandom(32'hdc65)};
    repeat (8) @(negedge i_core_clk);
    i_reset = 1'b0;
    // reset contents and an unmapped place
    rd(SSW_OFF_TRIM_CTRL, 8'h00);
    rd(SSW_OFF_TRIM_CODE, SSW_MIDCODE);
    rd(SSW_OFF_TRIM_UPPER, 8'hff);
    rd(SSW_OFF_TRIM_LOWER, 8'h00);
    wr(8'ha0, 8'h55);
    rd(8'ha0, 8'h00);
    tchk(1'b0, 1'b0, 2'h0, SSW_MIDCODE);
    // code change while disabled
    wr(SSW_OFF_TRIM_CODE, 8'h90);
    rd(SSW_OFF_TRIM_CODE, 8'h90);
    tchk(1'b0, 1'b0, 2'h0, SSW_MIDCODE);
    // every midcode selection
    for (int s = 0; s < 4; s++) begin
      wr(SSW_OFF_TRIM_CTRL, {6'h01, s[1:0]});
      tchk(1'b1, 1'b0, s[1:0], 8'h90);
    end
    wr(SSW_OFF_TRIM_CTRL, 8'hff);
    rd(SSW_OFF_TRIM_CTRL, 8'h07);
    // limits: above, equal, below, inside, crossed
    wr(SSW_OFF_TRIM_UPPER, 8'h80);
    tchk(1'b1, 1'b0, 2'h3, 8'h80);
    wr(SSW_OFF_TRIM_CODE, 8'h80);
    tchk(1'b1, 1'b0, 2'h3, 8'h80);
    wr(SSW_OFF_TRIM_LOWER, 8'h20);
    wr(SSW_OFF_TRIM_CODE, 8'h10);
    tchk(1'b1, 1'b0, 2'h3, 8'h20);
    wr(SSW_OFF_TRIM_CODE, 8'h50);
    tchk(1'b1, 1'b0, 2'h3, 8'h50);
    wr(SSW_OFF_TRIM_LOWER, 8'h90);
    tchk(1'b0, 1'b1, 2'h3, 8'h50);
    wr(SSW_OFF_TRIM_LOWER, 8'h00);
    wr(SSW_OFF_TRIM_CTRL, 8'h01);
    wr(SSW_OFF_TRIM_CODE, 8'h33);
    tchk(1'b0, 1'b0, 2'h1, 8'h50);
    // random codes against upper limit 0x80
    wr(SSW_OFF_TRIM_CTRL, 8'h04);
    wr(SSW_OFF_TRIM_CODE, SSW_MIDCODE);
    tchk(1'b1, 1'b0, 2'h0, SSW_MIDCODE);
    for (int k = 0; k < 8; k++) begin
      c = 8'($urandom());
      wr(SSW_OFF_TRIM_CODE, c);
      tchk(1'b1, 1'b0, 2'h0, (c > 8'h80) ? 8'h80 : c);
    end
    // read and write together returns the old value
    rd_q.push_back(c);
    cyc(1'b1, 1'b1, SSW_OFF_TRIM_CODE, 8'h44, 1'b0, 1'b0);
    rd(SSW_OFF_TRIM_CODE, 8'h44);
    // live status bytes and warning
    for (int n = 0; n < 24; n++) begin
      rnd = {$urandom(), $urandom()};
      det = rnd[44:0];
      if (n[0]) det.limit = '0;
      i_detect = det;
      i_dual_is_digital = rnd[54:50];
      wr(SSW_OFF_OV_LOW, 8'h00);
      ovs = pick(det.ov_dual, det.ov_second, rnd[54:50]);
      uvs = pick(det.uv_dual, det.uv_second, rnd[54:50]);
      warn_q.push_back(|det.limit | |((det.ov_second | det.uv_second) & rnd[54:50]));
      rd(SSW_OFF_OV_LOW, {ovs[2:0], det.ov_main}, 1'b1);
      rd(SSW_OFF_OV_HIGH, {6'h00, ovs[4:3]});
      rd(SSW_OFF_UV_LOW, {uvs[2:0], det.uv_main});
      rd(SSW_OFF_UV_HIGH, {6'h00, uvs[4:3]});
      rd(SSW_OFF_LIM_LOW, det.limit[7:0]);
      rd(SSW_OFF_LIM_HIGH, {6'h00, det.limit[9:8]});
      rd(SSW_OFF_GPI, {3'h0, det.gpi_level});
    end
    // a changing level shows on the very next read
    i_detect.gpi_level = ~det.gpi_level;
    rd(SSW_OFF_GPI, {3'h0, ~det.gpi_level});
    // second reset in mid-run
    i_reset = 1'b1;
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    i_reset = 1'b0;
    rd(SSW_OFF_TRIM_CODE, SSW_MIDCODE);
    tchk(1'b0, 1'b0, 2'h0, SSW_MIDCODE);
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
